// ### design/ues_pkg.sv
/*
 Constants, command kinds and the status byte layout for the endpoint
 status, stall and validate logic. Assumes one 16-endpoint controller.
*/
// Functional notes
// - Each endpoint status byte is read by codes 50h-5Fh with one data byte.
// - Reading a status byte clears that endpoint's interrupt bit.
// - Status bits are read-only; only device events and the stall, unstall, validate and read commands change them.
// - Bit 7 is the halt flag: set by stall, cleared by unstall.
// - A SETUP token releases a stalled control endpoint whatever the packet holds.
// - Leaving the stall state flushes the buffer and forces DATA0 next.
// - Stall commands are codes 40h-4Fh, one per endpoint, no data phase.
// - Unstall commands are codes 80h-8Fh, one per endpoint, no data phase.
// - Bit 6 shows secondary buffer full, bit 5 primary buffer full.
// - Bit 4 is the expected data toggle of the next packet.
// - Bit 3 flags a clobbered setup; a read clears it only after storing ends.
// - Bit 2 shows a setup packet in the buffer; bit 0 is reserved.
// - Bit 1 shows which buffer the microcontroller accesses: 0 primary.
// - Validate sets the IN buffer full flag so the next IN token sends it.
// - On a double-buffered IN endpoint validate also swaps the accessed buffer.
// - Validate commands are codes 61h-6Fh, no data phase.
// - Every status bit is zero after device reset.
package ues_pkg;
   // ==========================================================
   // Sizes and command groups
   localparam int          NUM_EP      = 16;
   localparam logic [3:0]  GRP_STALL   = 4'h4;
   localparam logic [3:0]  GRP_READ    = 4'h5;
   localparam logic [3:0]  GRP_VALID   = 4'h6;
   localparam logic [3:0]  GRP_UNSTALL = 4'h8;
   localparam logic [3:0]  EP_CTRL_OUT = 4'h0;
   localparam logic [3:0]  EP_CTRL_IN  = 4'h1;
   // ==========================================================
   // Status byte layout
   localparam int          BIT_HALT    = 7;
   localparam int          BIT_FULL1   = 6;
   localparam int          BIT_FULL0   = 5;
   localparam int          BIT_TOGGLE  = 4;
   localparam int          BIT_CLOB    = 3;
   localparam int          BIT_SETUP   = 2;
   localparam int          BIT_HOST_SIDE_BUFFER_SELECT  = 1;
   localparam logic [7:0]  STATUS_RST  = 8'h00;
   localparam logic [15:0] DBL_DEFAULT = 16'h0000;
   // ==========================================================
   // Command kinds
   typedef enum logic [4:0] {
      CMD_NONE    = 5'h01,
      CMD_STALL   = 5'h02,
      CMD_UNSTALL = 5'h04,
      CMD_READ    = 5'h08,
      CMD_VALID   = 5'h10
   } ues_cmd_e;
endpackage : ues_pkg

// ### design/ues_top.sv
/*
 Per-endpoint status, stall/unstall and IN validate logic.
 Assumes the parallel command front end and the USB engine run on clk_i,
 so their strobes are single-cycle pulses needing no synchroniser.
*/
`timescale 1ns/1ps
module ues_top
   import ues_pkg::*;
#(
   parameter logic [NUM_EP-1:0] DBL_BUF = DBL_DEFAULT
)(
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              reset_n_i,
   // Command port
   input  wire logic              cmd_valid_i,
   input  wire logic [7:0]        cmd_code_i,
   // Status read answer
   output logic      [7:0]        rd_data_o,
   output logic                   rd_valid_o,
   // Interrupt register clear strobes
   output logic      [NUM_EP-1:0] int_clr_o,
   // USB engine events
   input  wire logic [3:0]        evt_ep_i,
   input  wire logic              setup_tok_i,
   input  wire logic              setup_wr_i,
   input  wire logic              setup_done_i,
   input  wire logic              out_rx_i,
   input  wire logic              in_tx_i,
   // State for the USB engine
   output logic      [NUM_EP-1:0] halt_o,
   output logic      [NUM_EP-1:0] toggle_o
);

   // ==========================================================
   // Helpers
   function automatic logic [3:0] ep_of(input logic [7:0] code);
      return code[3:0];
   endfunction : ep_of

   function automatic logic [NUM_EP-1:0] one_hot(input logic [3:0] ep);
      logic [NUM_EP-1:0] v;
      v = '0;
      v[ep] = 1'b1;
      return v;
   endfunction : one_hot

   function automatic ues_cmd_e decode(input logic [7:0] code);
      ues_cmd_e k;
      k = CMD_NONE;
      unique case (code[7:4])
         GRP_STALL:   k = CMD_STALL;
         GRP_UNSTALL: k = CMD_UNSTALL;
         GRP_READ:    k = CMD_READ;
         // Code 60h has no IN endpoint behind it and is ignored
         GRP_VALID:   k = (code[3:0] == EP_CTRL_OUT) ? CMD_NONE : CMD_VALID;
         default:     k = CMD_NONE;
      endcase
      return k;
   endfunction : decode

   // ==========================================================
   // Per-endpoint state
   logic [NUM_EP-1:0] halt;
   logic [NUM_EP-1:0] full0;
   logic [NUM_EP-1:0] full1;
   logic [NUM_EP-1:0] tog;
   logic [NUM_EP-1:0] clob;
   logic [NUM_EP-1:0] setp;
   logic [NUM_EP-1:0] cbuf;
   logic [NUM_EP-1:0] busy;

   logic [NUM_EP-1:0] next_full0;
   logic [NUM_EP-1:0] next_full1;
   logic [NUM_EP-1:0] next_tog;
   logic [NUM_EP-1:0] next_cbuf;

   function automatic logic [7:0] status_of(input logic [3:0] e,
         input logic [NUM_EP-1:0] h, input logic [NUM_EP-1:0] f1,
         input logic [NUM_EP-1:0] f0, input logic [NUM_EP-1:0] t,
         input logic [NUM_EP-1:0] c, input logic [NUM_EP-1:0] s,
         input logic [NUM_EP-1:0] b);
      // Bit 0 stays zero
      return {h[e], f1[e], f0[e], t[e], c[e], s[e], b[e], 1'b0};
   endfunction : status_of

   // ==========================================================
   // Command and event decode
   ues_cmd_e          cmd_kind;
   logic [3:0]        cmd_ep;
   logic [NUM_EP-1:0] cmd_sel;
   logic [NUM_EP-1:0] ev_sel;
   logic [NUM_EP-1:0] stall_sel;
   logic [NUM_EP-1:0] unstall_sel;
   logic [NUM_EP-1:0] valid_sel;
   logic [NUM_EP-1:0] read_sel;
   logic [NUM_EP-1:0] ctrl_sel;
   logic [NUM_EP-1:0] reinit;

   assign cmd_kind    = cmd_valid_i ? decode(cmd_code_i) : CMD_NONE;
   assign cmd_ep      = ep_of(cmd_code_i);
   assign cmd_sel     = one_hot(cmd_ep);
   assign ev_sel      = one_hot(evt_ep_i);
   assign ctrl_sel    = one_hot(EP_CTRL_OUT) | one_hot(EP_CTRL_IN);
   assign stall_sel   = (cmd_kind == CMD_STALL)   ? cmd_sel : '0;
   assign valid_sel   = (cmd_kind == CMD_VALID)   ? cmd_sel : '0;
   assign read_sel    = (cmd_kind == CMD_READ)    ? cmd_sel : '0;
   assign unstall_sel = ((cmd_kind == CMD_UNSTALL) ? cmd_sel : '0)
                      | (setup_tok_i ? ctrl_sel : '0);
   // Only an endpoint that really leaves the stall state is reset
   assign reinit      = unstall_sel & halt & ~stall_sel;

   // ==========================================================
   // Halt flag
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         halt <= '0;
      end else begin
         // A stall in the same cycle as a SETUP release keeps the endpoint halted
         halt <= (halt & ~unstall_sel) | stall_sel;
      end
   end

   // ==========================================================
   // Buffer full flags, toggle and buffer select
   always_comb begin
      next_full0 = full0;
      next_full1 = full1;
      next_tog   = tog;
      next_cbuf  = cbuf;
      for (int e = 0; e < NUM_EP; e++) begin
         if (reinit[e]) begin
            next_full0[e] = 1'b0;
            next_full1[e] = 1'b0;
            next_tog[e]   = 1'b0;
            next_cbuf[e]  = 1'b0;
         end
         // USB side of a double buffer is the one the CPU is not using
         if (in_tx_i && ev_sel[e]) begin
            if (DBL_BUF[e] && !cbuf[e]) begin
               next_full1[e] = 1'b0;
            end else begin
               next_full0[e] = 1'b0;
            end
         end
         if ((in_tx_i || out_rx_i) && ev_sel[e]) begin
            next_tog[e] = ~tog[e];
         end
         if (setup_wr_i && ctrl_sel[e]) begin
            next_tog[e] = 1'b1;
         end
         // Sets come last so they win over any clear in the same cycle
         if (out_rx_i && ev_sel[e]) begin
            if (DBL_BUF[e] && !cbuf[e]) begin
               next_full1[e] = 1'b1;
            end else begin
               next_full0[e] = 1'b1;
            end
         end
         if (valid_sel[e]) begin
            if (cbuf[e]) begin
               next_full1[e] = 1'b1;
            end else begin
               next_full0[e] = 1'b1;
            end
            if (DBL_BUF[e]) begin
               next_cbuf[e] = ~cbuf[e];
            end
         end
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         full0 <= '0;
         full1 <= '0;
      end else begin
         full0 <= next_full0;
         full1 <= next_full1;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         tog <= '0;
      end else begin
         tog <= next_tog;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cbuf <= '0;
      end else begin
         cbuf <= next_cbuf;
      end
   end

   // ==========================================================
   // Setup tracking on the control OUT endpoint
   logic setup_new;
   assign setup_new = setup_wr_i;

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         setp <= '0;
         busy <= '0;
      end else begin
         if (reinit[EP_CTRL_OUT] || (out_rx_i && evt_ep_i == EP_CTRL_OUT)) begin
            setp[EP_CTRL_OUT] <= 1'b0;
         end
         if (setup_done_i) begin
            busy[EP_CTRL_OUT] <= 1'b0;
         end
         if (setup_new) begin
            setp[EP_CTRL_OUT] <= 1'b1;
            busy[EP_CTRL_OUT] <= 1'b1;
         end
      end
   end

   // A read during storing would hide a clobber still in progress
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         clob <= '0;
      end else begin
         if (read_sel[EP_CTRL_OUT] && !busy[EP_CTRL_OUT]) begin
            clob[EP_CTRL_OUT] <= 1'b0;
         end
         if (setup_new && setp[EP_CTRL_OUT]) begin
            clob[EP_CTRL_OUT] <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Status read answer and interrupt clear
   // The byte shows the state before this cycle's own updates
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rd_data_o  <= STATUS_RST;
         rd_valid_o <= 1'b0;
      end else begin
         rd_valid_o <= (cmd_kind == CMD_READ);
         if (cmd_kind == CMD_READ) begin
            rd_data_o <= status_of(cmd_ep, halt, full1, full0, tog, clob, setp, cbuf);
         end
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         int_clr_o <= '0;
      end else begin
         int_clr_o <= read_sel;
      end
   end

   assign halt_o   = halt;
   assign toggle_o = tog;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   // Selected endpoint bits, so that past values are taken of plain signals
   logic cur_halt;
   logic cur_cbuf;
   assign cur_halt = halt[cmd_ep];
   assign cur_cbuf = cbuf[cmd_ep];

   sequence s_read;
      cmd_kind == CMD_READ;
   endsequence

   sequence s_quiet;
      !setup_tok_i && !setup_wr_i && !out_rx_i && !in_tx_i;
   endsequence

   property p_read_answer;
      s_read |=> rd_valid_o && (int_clr_o == one_hot($past(cmd_ep)));
   endproperty
   a_read_answer: assert property (p_read_answer)
      else $error("status read gave no answer or wrong interrupt clear");

   property p_read_alone;
      !(cmd_kind == CMD_READ) |=> !rd_valid_o && int_clr_o == '0;
   endproperty
   a_read_alone: assert property (p_read_alone)
      else $error("read answer without a read command");

   property p_reserved_zero;
      rd_valid_o |-> rd_data_o[0] == 1'b0 && rd_data_o[BIT_HALT] == $past(cur_halt);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("status byte reserved bit or halt bit wrong");

   property p_stall;
      cmd_kind == CMD_STALL |=> halt[$past(cmd_ep)];
   endproperty
   a_stall: assert property (p_stall)
      else $error("stall command did not halt the endpoint");

   property p_unstall_reinit;
      (((cmd_kind == CMD_UNSTALL) && halt[cmd_ep]) and s_quiet)
         |=> !halt[$past(cmd_ep)] && !full0[$past(cmd_ep)]
             && !full1[$past(cmd_ep)] && !tog[$past(cmd_ep)];
   endproperty
   a_unstall_reinit: assert property (p_unstall_reinit)
      else $error("unstall left endpoint halted or not flushed");

   property p_setup_release;
      setup_tok_i && halt[EP_CTRL_OUT] && !stall_sel[EP_CTRL_OUT]
         |=> !halt[EP_CTRL_OUT] ##1 (!halt[EP_CTRL_OUT] || $past(stall_sel[EP_CTRL_OUT]));
   endproperty
   a_setup_release: assert property (p_setup_release)
      else $error("SETUP token did not release the control endpoint");

   property p_validate_single;
      (((cmd_kind == CMD_VALID) && !DBL_BUF[cmd_ep] && !reinit[cmd_ep]) and s_quiet)
         |=> full0[$past(cmd_ep)] && $stable(cbuf);
   endproperty
   a_validate_single: assert property (p_validate_single)
      else $error("validate did not load the primary buffer");

   property p_validate_double;
      (cmd_kind == CMD_VALID) && DBL_BUF[cmd_ep] && !reinit[cmd_ep]
         |=> cbuf[$past(cmd_ep)] != $past(cur_cbuf);
   endproperty
   a_validate_double: assert property (p_validate_double)
      else $error("validate did not swap the double buffer");

   property p_clobber;
      setup_wr_i && setp[EP_CTRL_OUT] |=> clob[EP_CTRL_OUT] [*2];
   endproperty
   a_clobber: assert property (p_clobber)
      else $error("overwritten setup was not flagged");

   property p_clobber_hold;
      s_read ##0 (cmd_ep == EP_CTRL_OUT) && busy[EP_CTRL_OUT] && clob[EP_CTRL_OUT]
         |=> clob[EP_CTRL_OUT];
   endproperty
   a_clobber_hold: assert property (p_clobber_hold)
      else $error("clobber flag cleared while setup still storing");

   property p_valid_ep0_ignored;
      ((cmd_valid_i && cmd_code_i == {GRP_VALID, EP_CTRL_OUT}) and s_quiet)
         |=> $stable(full0[EP_CTRL_OUT]) && $stable(cbuf[EP_CTRL_OUT]);
   endproperty
   a_valid_ep0_ignored: assert property (p_valid_ep0_ignored)
      else $error("validate code for control OUT had an effect");

endmodule : ues_top

// ### tb/tb.sv
/*
 Self-checking bench for the endpoint status, stall and validate block.
 Assumes the host model as command source; the bench plays the USB engine.
*/
`timescale 1ns/1ps
module tb
   import ues_pkg::*;
;
   localparam logic [NUM_EP-1:0] DBL = 16'h0008;
   localparam logic [4:0] EV_TOK = 5'h10, EV_WR = 5'h08, EV_DONE = 5'h04;
   localparam logic [4:0] EV_OUT = 5'h02, EV_IN = 5'h01;
   logic              clk, reset_n, cmd_valid, rd_valid;
   logic              setup_tok, setup_wr, setup_done, out_rx, in_tx;
   logic [7:0]        cmd_code, rd_data;
   logic [3:0]        evt_ep;
   logic [NUM_EP-1:0] int_clr, halt, toggle;
   int                n_mismatch = 0;
   int                n_checks = 0;

   ues_top #(.DBL_BUF(DBL)) i_ues_top (
      .clk_i(clk), .reset_n_i(reset_n), .cmd_valid_i(cmd_valid), .cmd_code_i(cmd_code),
      .rd_data_o(rd_data), .rd_valid_o(rd_valid), .int_clr_o(int_clr), .evt_ep_i(evt_ep),
      .setup_tok_i(setup_tok), .setup_wr_i(setup_wr), .setup_done_i(setup_done),
      .out_rx_i(out_rx), .in_tx_i(in_tx), .halt_o(halt), .toggle_o(toggle));
   ues_host_model i_ues_host_model (.clk_i(clk), .cmd_valid_o(cmd_valid), .cmd_code_o(cmd_code));

   // ==========================================================
   // Clock, compare and access tasks
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t byte got %h exp %h", $time, got, exp);
      end
   endtask : chk_byte

   task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t vector got %h exp %h", $time, got, exp);
      end
   endtask : chk_vec

   task automatic rd(input logic [3:0] ep, input logic [7:0] exp);
      i_ues_host_model.send({GRP_READ, ep});
      chk_byte({7'h00, rd_valid}, 8'h01);
      chk_byte(rd_data, exp);
      chk_vec(int_clr, 16'h0001 << ep);
      @(posedge clk);
      #1;
      chk_vec(int_clr | {15'h0000, rd_valid}, 16'h0000);
   endtask : rd

   // Event strobes last one cycle; the index lines are scrambled when idle
   task automatic ev(input logic [3:0] ep, input logic [4:0] m);
      @(posedge clk);
      #1;
      evt_ep = ep;
      setup_tok = m[4];
      setup_wr = m[3];
      setup_done = m[2];
      out_rx = m[1];
      in_tx = m[0];
      @(posedge clk);
      #1;
      setup_tok = 1'b0;
      setup_wr = 1'b0;
      setup_done = 1'b0;
      out_rx = 1'b0;
      in_tx = 1'b0;
      evt_ep = ~ep;
   endtask : ev

   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : test_done

   initial begin
      repeat (5000) @(posedge clk);
      n_mismatch++;
      test_done();
   end

   // ==========================================================
   // Test sequence
   initial begin
      reset_n = 1'b0;
      evt_ep = 4'h0;
      setup_tok = 1'b0;
      setup_wr = 1'b0;
      setup_done = 1'b0;
      out_rx = 1'b0;
      in_tx = 1'b0;
      repeat (6) @(posedge clk);
      #1;
      reset_n = 1'b1;
      chk_vec(halt | toggle, 16'h0000);
      for (int e = 0; e < NUM_EP; e++) rd(e[3:0], 8'h00);
      for (int e = 0; e < NUM_EP; e++) i_ues_host_model.send({GRP_STALL, e[3:0]});
      chk_vec(halt, 16'hFFFF);
      rd(4'h5, 8'h80);
      for (int e = 0; e < NUM_EP; e++) i_ues_host_model.send({GRP_UNSTALL, e[3:0]});
      chk_vec(halt, 16'h0000);
      // Unknown groups and code 60h leave every endpoint untouched
      i_ues_host_model.send(8'h60);
      i_ues_host_model.send(8'h30);
      i_ues_host_model.send(8'h90);
      chk_vec(halt | toggle, 16'h0000);
      rd(4'h0, 8'h00);
      ev(4'h2, EV_OUT);
      rd(4'h2, 8'h30);
      rd(4'h2, 8'h30);
      i_ues_host_model.send(8'h42);
      i_ues_host_model.send(8'h82);
      rd(4'h2, 8'h00);
      i_ues_host_model.send(8'h64);
      rd(4'h4, 8'h20);
      ev(4'h4, EV_IN);
      rd(4'h4, 8'h10);
      for (int e = 1; e < NUM_EP; e++) i_ues_host_model.send({GRP_VALID, e[3:0]});
      rd(4'h1, 8'h20);
      rd(4'hF, 8'h20);
      rd(4'h3, 8'h22);
      i_ues_host_model.send(8'h63);
      rd(4'h3, 8'h60);
      // Endpoint 7 still holds its validated primary buffer, stalling does not flush
      i_ues_host_model.send_pair(8'h47, 8'h57);
      chk_byte(rd_data, 8'hA0);
      chk_vec(int_clr, 16'h0080);
      i_ues_host_model.send(8'h40);
      i_ues_host_model.send(8'h41);
      chk_vec(halt, 16'h0083);
      ev(4'h0, EV_TOK);
      chk_vec(halt, 16'h0080);
      rd(4'h1, 8'h00);
      ev(4'h0, EV_WR);
      chk_vec(toggle, 16'h0013);
      ev(4'h0, EV_WR);
      rd(4'h0, 8'h1C);
      rd(4'h0, 8'h1C);
      ev(4'h0, EV_DONE);
      rd(4'h0, 8'h1C);
      rd(4'h0, 8'h14);
      i_ues_host_model.restall_checked(rd_data, 4'h0);
      chk_vec(halt, 16'h0081);
      // Reset again in mid-run
      @(posedge clk);
      #1;
      reset_n = 1'b0;
      @(posedge clk);
      #1;
      reset_n = 1'b1;
      chk_vec(halt | toggle, 16'h0000);
      rd(4'h3, 8'h00);
      test_done();
   end
endmodule : tb

// ### tb/ues_host_model.sv
/*
 Behavioural microcontroller on the command port of the endpoint status block.
 Assumes it shares clk_i with the block and is driven by task calls from tb.
*/
`timescale 1ns/1ps
module ues_host_model
   import ues_pkg::*;
(
   // Clock
   input  wire logic       clk_i,
   // Command port
   output logic            cmd_valid_o,
   output logic [7:0]      cmd_code_o
);
   // ==========================================================
   // Command issue
   initial begin
      cmd_valid_o = 1'b0;
      cmd_code_o  = 8'h00;
   end

   // Code lines are scrambled while idle so a stale code can never pass for a command
   task automatic send(input logic [7:0] code);
      @(posedge clk_i);
      #1;
      cmd_valid_o = 1'b1;
      cmd_code_o  = code;
      @(posedge clk_i);
      #1;
      cmd_valid_o = 1'b0;
      cmd_code_o  = ~code;
   endtask : send

   task automatic send_pair(input logic [7:0] a, input logic [7:0] b);
      @(posedge clk_i);
      #1;
      cmd_valid_o = 1'b1;
      cmd_code_o  = a;
      @(posedge clk_i);
      #1;
      cmd_code_o  = b;
      @(posedge clk_i);
      #1;
      cmd_valid_o = 1'b0;
      cmd_code_o  = ~b;
   endtask : send_pair

   // A clobbered setup is abandoned; otherwise the control endpoint is halted again
   task automatic restall_checked(input logic [7:0] status, input logic [3:0] ep);
      if (status[BIT_CLOB] !== 1'b0) begin
         return;
      end
      send({GRP_STALL, ep});
   endtask : restall_checked
endmodule : ues_host_model
